// ### core/link_err_pkg.sv
/*
 * Shared constants and carrier types of the link error flag logic.
 * Assumes a 32-bit APB slave port with byte addresses in the low address bits.
 */
package link_err_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 8;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ENABLES = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MAIN_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h0c;

    // Flag bit positions.
    localparam int BIT_STUFF = 7;
    localparam int BIT_RESERVED = 6;
    localparam int BIT_BUFFER = 5;
    localparam int BIT_TURN = 4;
    localparam int BIT_PARTIAL = 3;
    localparam int BIT_DATA_CRC = 2;
    localparam int BIT_TOKEN_CRC = 1;
    localparam int BIT_PID = 0;

    // Summary error bit of the main interrupt status word.
    localparam int BIT_SUMMARY = 1;
    // Host role select bit of the control word.
    localparam int BIT_HOST_ROLE = 0;

    localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [FLAG_W-1:0] ENABLES_RESET = 8'h00;
    localparam logic [FLAG_W-1:0] FLAG_MASK = 8'hbf;

    // Turnaround limit in bit times and the width of its counter.
    localparam int TURN_LIMIT_BITS = 16;
    localparam int TURN_CNT_W = 5;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic stuff_violation;
        logic pid_end;
        logic pid_check_ok;
        logic token_end;
        logic token_crc_ok;
        logic data_end;
        logic data_crc_ok;
        logic [2:0] data_bit_rem;
        logic bus_req_pending;
        logic data_must_move;
        logic bus_grant;
        logic transmitting;
        logic data_byte;
        logic buffer_full;
    } sie_events_t;

endpackage

// ### core/turnaround_timer.sv
/*
 * Bus turnaround timer: counts bit times from an end of packet until the
 * bus leaves idle, and pulses a timeout once the limit is passed.
 * Assumes bit_tick_i is a one-cycle enable per bit time from the line logic.
 */
`timescale 1ns/10ps
module turnaround_timer #(
    parameter int LIMIT = link_err_pkg::TURN_LIMIT_BITS
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Line events
    input wire logic arm_i,
    input wire logic bit_tick_i,
    input wire logic bus_idle_i,
    // Result
    output logic timeout_o
);

    typedef struct packed {
        logic armed;
        logic [link_err_pkg::TURN_CNT_W-1:0] count;
        logic timeout;
    } turn_state_t;

    turn_state_t state_q;
    turn_state_t state_d;

    always_comb
    begin
        state_d = state_q;
        state_d.timeout = 1'b0;
        if (arm_i)
        begin
            state_d.armed = 1'b1;
            state_d.count = '0;
        end
        else if (state_q.armed && !bus_idle_i)
        begin
            state_d.armed = 1'b0;
        end
        else if (state_q.armed && bit_tick_i)
        begin
            // More than the limit: the tick after the limit-th one fires.
            if (state_q.count == link_err_pkg::TURN_CNT_W'(LIMIT))
            begin
                state_d.timeout = 1'b1;
                state_d.armed = 1'b0;
            end
            else
            begin
                state_d.count = state_q.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign timeout_o = state_q.timeout;

    a_turn_no_busy: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_q.armed && !bus_idle_i && !arm_i) |=> !state_q.armed && !timeout_o)
        else $error("Turnaround timer kept running after the bus left idle.");

endmodule

// ### core/usb_error_status_flags.sv
/*
 * Sticky link error flags with enables, summary error bit and APB slave.
 * Assumes the packet engine gives one-cycle event pulses synchronous to
 * clock_i and a bit time enable; APB master follows the usual handshake.
 */
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module usb_error_status_flags #(
    parameter int TURN_LIMIT = link_err_pkg::TURN_LIMIT_BITS
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // APB slave
    input wire link_err_pkg::apb_req_t apb_i,
    output logic [link_err_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Packet engine events
    input wire link_err_pkg::sie_events_t sie_i,
    input wire logic bit_tick_i,
    input wire logic bus_idle_i,
    input wire logic eop_turn_i,
    // Results to packet engine and interrupt logic
    output logic packet_reject_o,
    output logic token_reject_o,
    output logic store_byte_o,
    output logic underflow_o,
    output logic overflow_o,
    output logic host_role_select_o,
    output logic error_summary_o
);

    typedef struct packed {
        logic [link_err_pkg::FLAG_W-1:0] flags;
        logic [link_err_pkg::FLAG_W-1:0] enables;
        logic host_role;
        logic summary;
        logic packet_reject;
        logic token_reject;
        logic store_byte;
        logic underflow;
        logic overflow;
        logic pready;
        logic pslverr;
        logic [link_err_pkg::DATA_W-1:0] prdata;
    } top_state_t;

    top_state_t state_q;
    top_state_t state_d;
    logic turn_timeout;
    logic [link_err_pkg::FLAG_W-1:0] set_vec;
    logic [link_err_pkg::FLAG_W-1:0] clear_vec;
    logic missed_grant;
    logic token_fail;
    logic access_done;
    logic setup_phase;

    function automatic logic addr_mapped(input logic [link_err_pkg::ADDR_W-1:0] addr);
        addr_mapped = (addr == link_err_pkg::OFS_FLAGS) || (addr == link_err_pkg::OFS_ENABLES)
            || (addr == link_err_pkg::OFS_MAIN_STATUS) || (addr == link_err_pkg::OFS_CONTROL);
    endfunction

    function automatic logic [link_err_pkg::DATA_W-1:0] widen(
        input logic [link_err_pkg::FLAG_W-1:0] value);
        widen = {{(link_err_pkg::DATA_W-link_err_pkg::FLAG_W){1'b0}}, value};
    endfunction

    turnaround_timer #(
        .LIMIT(TURN_LIMIT)
    ) u_turn (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .arm_i(eop_turn_i),
        .bit_tick_i(bit_tick_i),
        .bus_idle_i(bus_idle_i),
        .timeout_o(turn_timeout)
    );

    // A grant that has not come by the time data must move is a fault.
    assign missed_grant = sie_i.bus_req_pending && sie_i.data_must_move && !sie_i.bus_grant;
    assign token_fail = sie_i.token_end && !sie_i.token_crc_ok && !state_q.host_role;
    assign setup_phase = apb_i.psel && !apb_i.penable;
    assign access_done = apb_i.psel && apb_i.penable && state_q.pready;

    always_comb
    begin
        set_vec = '0;
        set_vec[link_err_pkg::BIT_STUFF] = sie_i.stuff_violation;
        set_vec[link_err_pkg::BIT_BUFFER] = missed_grant
            || (sie_i.data_byte && sie_i.buffer_full);
        set_vec[link_err_pkg::BIT_TURN] = turn_timeout;
        set_vec[link_err_pkg::BIT_PARTIAL] = sie_i.data_end
            && (sie_i.data_bit_rem != 3'h0);
        set_vec[link_err_pkg::BIT_DATA_CRC] = sie_i.data_end && !sie_i.data_crc_ok;
        set_vec[link_err_pkg::BIT_TOKEN_CRC] = token_fail;
        set_vec[link_err_pkg::BIT_PID] = sie_i.pid_end && !sie_i.pid_check_ok;
    end

    always_comb
    begin
        clear_vec = '0;
        if (access_done && apb_i.pwrite && (apb_i.paddr == link_err_pkg::OFS_FLAGS))
        begin
            // Only ones clear, and the reserved bit is never touched.
            clear_vec = apb_i.pwdata[link_err_pkg::FLAG_W-1:0] & link_err_pkg::FLAG_MASK;
        end
    end

    always_comb
    begin
        state_d = state_q;
        // Set beats clear, so an error in the clearing cycle is not lost.
        state_d.flags = ((state_q.flags & ~clear_vec) | set_vec)
            & link_err_pkg::FLAG_MASK;
        state_d.packet_reject = sie_i.stuff_violation
            || (sie_i.data_end && !sie_i.data_crc_ok);
        state_d.token_reject = token_fail;
        state_d.store_byte = sie_i.data_byte && !sie_i.buffer_full;
        state_d.underflow = missed_grant && sie_i.transmitting;
        state_d.overflow = missed_grant && !sie_i.transmitting;
        state_d.pready = 1'b0;
        state_d.pslverr = 1'b0;
        if (setup_phase)
        begin
            state_d.pready = 1'b1;
            state_d.pslverr = !addr_mapped(apb_i.paddr);
            state_d.prdata = '0;
            if (!apb_i.pwrite)
            begin
                unique case (apb_i.paddr)
                    link_err_pkg::OFS_FLAGS: state_d.prdata = widen(state_q.flags);
                    link_err_pkg::OFS_ENABLES: state_d.prdata = widen(state_q.enables);
                    link_err_pkg::OFS_MAIN_STATUS:
                        state_d.prdata[link_err_pkg::BIT_SUMMARY] = state_q.summary;
                    link_err_pkg::OFS_CONTROL:
                        state_d.prdata[link_err_pkg::BIT_HOST_ROLE] = state_q.host_role;
                    default: state_d.prdata = '0;
                endcase
            end
        end
        else if (state_q.pready && !access_done)
        begin
            state_d.pready = 1'b1;
            state_d.pslverr = state_q.pslverr;
        end
        if (access_done && apb_i.pwrite)
        begin
            if (apb_i.paddr == link_err_pkg::OFS_ENABLES)
            begin
                state_d.enables = apb_i.pwdata[link_err_pkg::FLAG_W-1:0]
                    & link_err_pkg::FLAG_MASK;
            end
            if (apb_i.paddr == link_err_pkg::OFS_CONTROL)
            begin
                state_d.host_role = apb_i.pwdata[link_err_pkg::BIT_HOST_ROLE];
            end
        end
        // Formed last so that a new enable word takes effect on the same edge.
        state_d.summary = |(state_d.flags & state_d.enables);
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= '0;
            state_q.flags <= link_err_pkg::FLAGS_RESET;
            state_q.enables <= link_err_pkg::ENABLES_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign prdata_o = state_q.prdata;
    assign pready_o = state_q.pready;
    assign pslverr_o = state_q.pslverr;
    assign packet_reject_o = state_q.packet_reject;
    assign token_reject_o = state_q.token_reject;
    assign store_byte_o = state_q.store_byte;
    assign underflow_o = state_q.underflow;
    assign overflow_o = state_q.overflow;
    assign host_role_select_o = state_q.host_role;
    assign error_summary_o = state_q.summary;

    a_summary_gated: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        error_summary_o == |(state_q.flags & state_q.enables))
        else $error("Summary bit does not follow the enabled flags.");

    a_summary_or: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (|(state_d.flags & state_d.enables)) |=> error_summary_o)
        else $error("Qualified error did not raise the summary bit.");

    a_flag_sticky: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_q.flags[link_err_pkg::BIT_PID] && !clear_vec[link_err_pkg::BIT_PID])
        |=> state_q.flags[link_err_pkg::BIT_PID])
        else $error("Error flag fell without a write of one.");

    a_set_at_once: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (sie_i.pid_end && !sie_i.pid_check_ok) |=> state_q.flags[link_err_pkg::BIT_PID])
        else $error("Identifier failure flag not set on the next edge.");

    a_stuff_reject: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        sie_i.stuff_violation |=> packet_reject_o && state_q.flags[link_err_pkg::BIT_STUFF])
        else $error("Stuffing violation not flagged and rejected.");

    a_reserved_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !state_q.flags[link_err_pkg::BIT_RESERVED] && !state_q.enables[link_err_pkg::BIT_RESERVED])
        else $error("Reserved bit became set.");

    a_grant_fault: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        missed_grant |=> state_q.flags[link_err_pkg::BIT_BUFFER]
            && (underflow_o != overflow_o))
        else $error("Missed grant not reported as buffer fault.");

    a_truncate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (sie_i.data_byte && sie_i.buffer_full) |=> !store_byte_o
            && state_q.flags[link_err_pkg::BIT_BUFFER])
        else $error("Oversize packet byte was stored.");

    a_turn_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        turn_timeout |=> state_q.flags[link_err_pkg::BIT_TURN])
        else $error("Turnaround timeout not flagged.");

    a_partial_byte: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (sie_i.data_end && sie_i.data_bit_rem != 3'h0)
        |=> state_q.flags[link_err_pkg::BIT_PARTIAL])
        else $error("Partial byte not flagged.");

    a_data_crc: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (sie_i.data_end && !sie_i.data_crc_ok)
        |=> packet_reject_o && state_q.flags[link_err_pkg::BIT_DATA_CRC])
        else $error("Data check failure not flagged and rejected.");

    a_token_role: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (sie_i.token_end && !sie_i.token_crc_ok)
        |=> token_reject_o == !$past(state_q.host_role))
        else $error("Token check handled against the selected role.");

    a_zero_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (access_done && apb_i.pwrite && apb_i.paddr == link_err_pkg::OFS_FLAGS
            && apb_i.pwdata[7:0] == 8'h00)
        |=> state_q.flags == ($past(state_q.flags) | $past(set_vec)))
        else $error("Write of zero changed the flags.");

    a_apb_answer: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (setup_phase ##1 (apb_i.psel && apb_i.penable)) |-> pready_o)
        else $error("Slave did not answer in the first access cycle.");

endmodule

// ### test/usb_host_model.sv
/*
 * Host side traffic model: turns bench commands into packet engine events,
 * a free bit time tick and the bus idle level.
 * Assumes one command pulse at a time from the bench, driven after an edge.
 */
`timescale 1ns/10ps
module usb_host_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Commands from the bench
    input wire logic fire_i,
    input wire logic [3:0] kind_i,
    input wire logic [2:0] rem_i,
    input wire logic active_i,
    // Line side toward the error logic
    output link_err_pkg::sie_events_t sie_o,
    output logic bit_tick_o,
    output logic bus_idle_o,
    output logic eop_turn_o
);
    logic [1:0] div_q;
    link_err_pkg::sie_events_t ev;

    // The bit tick runs free, so the timer sees ticks whether or not the bus is idle.
    assign bus_idle_o = !active_i;

    always_comb
    begin
        ev = '0;
        ev.stuff_violation = fire_i && kind_i == 4'h0;
        ev.pid_end = fire_i && kind_i == 4'h1;
        ev.pid_check_ok = !ev.pid_end;
        ev.token_end = fire_i && kind_i == 4'h2;
        ev.token_crc_ok = !ev.token_end;
        ev.data_end = fire_i && (kind_i == 4'h3 || kind_i == 4'h4);
        ev.data_crc_ok = !(fire_i && kind_i == 4'h3);
        ev.data_bit_rem = (fire_i && kind_i == 4'h4) ? rem_i : 3'h0;
        ev.bus_req_pending = fire_i && (kind_i == 4'h5 || kind_i == 4'h6);
        ev.bus_grant = !ev.bus_req_pending;
        ev.data_must_move = ev.bus_req_pending;
        ev.transmitting = fire_i && kind_i == 4'h5;
        ev.data_byte = fire_i && (kind_i == 4'h7 || kind_i == 4'h8);
        ev.buffer_full = fire_i && kind_i == 4'h7;
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div_q <= 2'h0;
            bit_tick_o <= 1'b0;
            eop_turn_o <= 1'b0;
            sie_o <= '0;
        end
        else
        begin
            div_q <= div_q + 2'h1;
            bit_tick_o <= div_q == 2'h3;
            eop_turn_o <= fire_i && kind_i == 4'h9;
            sie_o <= ev;
        end
    end
endmodule

// ### test/tb.sv
/*
 * Self-checking bench of the link error flags: APB master, host traffic
 * model and a flag model kept in the bench.
 * Assumes the zero wait state APB slave and one-cycle event latency.
 */
`timescale 1ns/10ps
module tb;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    link_err_pkg::apb_req_t apb_q = '0;
    link_err_pkg::sie_events_t sie;
    logic [31:0] prdata, rd, rnd = 32'h4e;
    logic pready, pslverr, se, tick, idle, eop, host_role, summary;
    logic fire = 1'b0;
    logic active = 1'b0;
    logic [3:0] kind = 4'h0;
    logic [2:0] rem = 3'h0;
    logic [4:0] pulses, seen = 5'h00;
    logic [7:0] ef = 8'h00;
    logic [7:0] en = 8'h00;
    logic hr = 1'b0;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;

    always #25 clock_i = ~clock_i;

    usb_error_status_flags #(.TURN_LIMIT(16)) i_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .apb_i(apb_q), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sie_i(sie), .bit_tick_i(tick),
        .bus_idle_i(idle), .eop_turn_i(eop), .packet_reject_o(pulses[4]),
        .token_reject_o(pulses[3]), .store_byte_o(pulses[2]), .underflow_o(pulses[1]),
        .overflow_o(pulses[0]), .host_role_select_o(host_role), .error_summary_o(summary));

    usb_host_model i_host (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .fire_i(fire), .kind_i(kind), .rem_i(rem),
        .active_i(active), .sie_o(sie), .bit_tick_o(tick), .bus_idle_o(idle),
        .eop_turn_o(eop));

    always @(posedge clock_i)
    begin
        seen <= seen | pulses;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            give_verdict();
        end
    end

    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction

    function automatic logic [7:0] flag_of(input int k);
        case (k)
            0: return 8'h80;
            1: return 8'h01;
            2: return hr ? 8'h00 : 8'h02;
            3: return 8'h04;
            4: return 8'h08;
            5, 6, 7: return 8'h20;
            9: return 8'h10;
            default: return 8'h00;
        endcase
    endfunction

    // Order of bits: packet reject, token reject, store, underflow, overflow.
    function automatic logic [4:0] pulse_of(input int k);
        case (k)
            0, 3: return 5'h10;
            2: return hr ? 5'h00 : 5'h08;
            5: return 5'h02;
            6: return 5'h01;
            8: return 5'h04;
            default: return 5'h00;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clock_i);
        apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clock_i);
        apb_q.penable <= 1'b1;
        do
        begin
            @(posedge clock_i);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        if (k >= 16)
            chk("pready", 32'h0, 32'h1);
        rd = prdata;
        se = pslverr;
        apb_q.psel <= 1'b0;
        apb_q.penable <= 1'b0;
    endtask

    task automatic check_regs();
        apb(1'b0, link_err_pkg::OFS_FLAGS, 32'h0);
        chk("flags", rd, {24'h0, ef});
        apb(1'b0, link_err_pkg::OFS_MAIN_STATUS, 32'h0);
        chk("status_summary", rd & 32'h2, {30'h0, |(ef & en), 1'b0});
        chk("summary_out", {31'h0, summary}, {31'h0, |(ef & en)});
        chk("host_role", {31'h0, host_role}, {31'h0, hr});
    endtask

    // Idle is broken after eight cycles when brk is set, which disarms the timer.
    task automatic event_run(input int k, input logic brk);
        @(negedge clock_i);
        seen = 5'h00;
        @(posedge clock_i);
        kind <= k[3:0];
        rem <= 3'(xs() % 7 + 1);
        fire <= 1'b1;
        @(posedge clock_i);
        fire <= 1'b0;
        if (brk)
        begin
            repeat (8) @(posedge clock_i);
            active <= 1'b1;
            repeat (4) @(posedge clock_i);
            active <= 1'b0;
        end
        repeat (80) @(posedge clock_i);
        if (!brk)
            ef = ef | flag_of(k);
        chk("pulses", {27'h0, seen}, {27'h0, brk ? 5'h00 : pulse_of(k)});
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        logic [31:0] w;
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        check_regs();
        apb(1'b0, link_err_pkg::OFS_ENABLES, 32'h0);
        chk("enables_reset", rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped_err", {31'h0, se}, 32'h1);
        chk("unmapped_data", rd, 32'h0);
        $display("test reset values done");
        for (int p = 0; p < 3; p++)
        begin
            en = 8'(xs());
            apb(1'b1, link_err_pkg::OFS_ENABLES, {24'h0, en} | 32'h40);
            en = en & link_err_pkg::FLAG_MASK;
            apb(1'b0, link_err_pkg::OFS_ENABLES, 32'h0);
            chk("enables", rd, {24'h0, en});
            hr = p == 1;
            apb(1'b1, link_err_pkg::OFS_CONTROL, {31'h0, hr});
            for (int k = 0; k < 10; k++)
            begin
                event_run(k, 1'b0);
                check_regs();
            end
            apb(1'b1, link_err_pkg::OFS_FLAGS, 32'h0);
            apb(1'b1, link_err_pkg::OFS_FLAGS, 32'h40);
            check_regs();
            w = xs();
            apb(1'b1, link_err_pkg::OFS_FLAGS, w);
            ef = ef & ~w[7:0];
            check_regs();
            apb(1'b1, link_err_pkg::OFS_FLAGS, 32'hff);
            ef = 8'h00;
            check_regs();
            $display("test event pass %0d done", p);
        end
        event_run(9, 1'b1);
        check_regs();
        $display("test turnaround disarm done");
        event_run(0, 1'b0);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        ef = 8'h00;
        en = 8'h00;
        hr = 1'b0;
        check_regs();
        $display("test mid run reset done");
        give_verdict();
    end
endmodule
